// ### hdl/pic_mdio_slave.sv
`timescale 1ns/1ps
`default_nettype none
module pic_mdio_slave
    import pic_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    input  wire logic        mclk,    // Device clock
    input  wire logic        resetn,  // Sync reset, low
    input  wire logic        mdc_lvl, // Filtered management clock
    input  wire logic        mdio_lvl,// Filtered management data
    input  wire logic [15:0] rd_data, // Read data from bank
    output pic_pkg::pic_req_t req,    // Register request
    output logic             mdio_o,  // Data driven out
    output logic             mdio_oe  // High while driving
);
    import pic_pkg::*;

    pic_mdio_t r;
    pic_mdio_t n;
    logic      edge_p;
    logic [12:0] hdr;

    // ------------------------------------------------------------
    // Frame decoder, acts on rising management clock
    // ------------------------------------------------------------
    always_comb begin
        n      = r;
        n.rd   = 1'h0;
        n.wr   = 1'h0;
        n.mdc_q = mdc_lvl;
        edge_p = mdc_lvl & ~r.mdc_q;
        hdr    = {r.sh[11:0], mdio_lvl};
        if (edge_p) begin
            case (r.st)
                M_PRE: begin
                    if (mdio_lvl) begin
                        if (r.cnt != PRE_MIN) begin
                            n.cnt = r.cnt + 6'h01;
                        end
                    end else if (r.cnt == PRE_MIN) begin
                        n.st  = M_HDR;
                        n.cnt = 6'h00;
                    end else begin
                        n.cnt = 6'h00;
                    end
                end
                M_HDR: begin
                    n.sh  = {r.sh[14:0], mdio_lvl};
                    n.cnt = r.cnt + 6'h01;
                    if (r.cnt == HDR_BITS - 6'h01) begin
                        n.cnt  = 6'h00;
                        n.addr = hdr[4:0];
                        n.st   = M_SKIP;
                        if (hdr[12] && hdr[9:5] == PHY_ADDR) begin
                            if (hdr[11:10] == OP_RD) begin
                                n.rd = 1'h1;
                                n.st = M_TA;
                            end else if (hdr[11:10] == OP_WR) begin
                                n.st = M_TAW;
                            end
                        end
                    end
                end
                M_TA: begin
                    n.oe = 1'h1;
                    n.o  = 1'h0;
                    n.sh = rd_data;
                    n.st = M_RD;
                end
                M_RD: begin
                    if (r.cnt == DATA_BITS) begin
                        n.oe  = 1'h0;
                        n.o   = 1'h0;
                        n.cnt = 6'h00;
                        n.st  = M_PRE;
                    end else begin
                        n.o   = r.sh[15];
                        n.sh  = {r.sh[14:0], 1'h0};
                        n.cnt = r.cnt + 6'h01;
                    end
                end
                M_TAW: begin
                    n.cnt = r.cnt + 6'h01;
                    if (r.cnt == 6'h01) begin
                        n.cnt = 6'h00;
                        n.st  = M_WR;
                    end
                end
                M_WR: begin
                    n.sh  = {r.sh[14:0], mdio_lvl};
                    n.cnt = r.cnt + 6'h01;
                    if (r.cnt == DATA_BITS - 6'h01) begin
                        n.wr  = 1'h1;
                        n.cnt = 6'h00;
                        n.st  = M_PRE;
                    end
                end
                default: begin
                    n.cnt = r.cnt + 6'h01;
                    if (r.cnt == SKIP_BITS - 6'h01) begin
                        n.cnt = 6'h00;
                        n.st  = M_PRE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            r <= '{st: M_PRE, default: '0};
        end else begin
            r <= n;
        end
    end

    assign req     = '{rd: r.rd, wr: r.wr, addr: r.addr, data: r.sh};
    assign mdio_o  = r.o;
    assign mdio_oe = r.oe;
endmodule
`default_nettype wire

// ### hdl/pic_pkg.sv
`default_nettype none
package pic_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [4:0] REG_INT  = 5'h1b;
    localparam logic [4:0] REG_CTL1 = 5'h1e;
    localparam logic [4:0] REG_CTL2 = 5'h1f;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int EV_JABBER     = 7;
    localparam int EV_RX_ERR     = 6;
    localparam int EV_PAGE_RX    = 5;
    localparam int EV_PD_FAULT   = 4;
    localparam int EV_LP_ACK     = 3;
    localparam int EV_LINK_DOWN  = 2;
    localparam int EV_REM_FAULT  = 1;
    localparam int EV_LINK_UP    = 0;
    localparam int INT_EN_LSB    = 8;
    localparam int CTL1_MODE_LSB = 14;
    localparam int CTL1_POL      = 13;
    localparam int CTL1_MDIX     = 11;
    localparam int CTL1_LOOP     = 7;
    localparam int CTL2_XALG     = 15;
    localparam int CTL2_MDIX_SEL = 14;
    localparam int CTL2_XDIS     = 13;
    localparam int CTL2_ENERGY   = 12;
    localparam int CTL2_FORCE    = 11;
    localparam int CTL2_INT_LVL  = 9;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] EN_RST      = 8'h00;
    localparam logic [7:0] FLAGS_RST   = 8'h00;
    localparam logic [1:0] MODE_RST    = 2'h0;
    localparam logic       XALG_RST    = 1'h1;
    localparam logic [1:0] MODE_SPD_LA = 2'h0;
    localparam logic [1:0] MODE_ACT_LK = 2'h1;

    // ------------------------------------------------------------
    // Management frame counts
    // ------------------------------------------------------------
    localparam logic [5:0] PRE_MIN   = 6'h20;
    localparam logic [5:0] HDR_BITS  = 6'h0d;
    localparam logic [5:0] DATA_BITS = 6'h10;
    localparam logic [5:0] SKIP_BITS = 6'h12;
    localparam logic [1:0] OP_RD     = 2'h2;
    localparam logic [1:0] OP_WR     = 2'h1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  addr;
        logic [15:0] data;
    } pic_req_t;

    typedef struct packed {
        logic polarity_reversed;
        logic mdix_state;
        logic energy_detect;
        logic link_up;
        logic activity;
        logic speed_100;
    } pic_stat_t;

    typedef struct packed {
        logic remote_loopback;
        logic crossover_algorithm_select;
        logic mdix_select;
        logic auto_crossover_disable;
        logic force_link;
    } pic_ctrl_t;

    typedef enum logic [2:0] {
        M_PRE, M_HDR, M_TA, M_RD, M_TAW, M_WR, M_SKIP
    } pic_mst_t;

    typedef struct packed {
        pic_mst_t    st;
        logic [5:0]  cnt;
        logic [15:0] sh;
        logic [4:0]  addr;
        logic        mdc_q;
        logic        o;
        logic        oe;
        logic        rd;
        logic        wr;
    } pic_mdio_t;

    typedef struct packed {
        logic [7:0]  en;
        logic [7:0]  flags;
        logic [1:0]  led_mode;
        logic        loopback;
        logic        xalg;
        logic        mdix_sel;
        logic        xdis;
        logic        force_link;
        logic        int_lvl;
        logic [15:0] rd_data;
        logic        intr;
        logic        ind0;
        logic        ind1;
    } pic_regs_t;

endpackage
`default_nettype wire

// ### hdl/pic_regs.sv
`timescale 1ns/1ps
`default_nettype none
module pic_regs
    import pic_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    input  wire logic       mclk,          // Device clock, 125 MHz
    input  wire logic       resetn,        // Sync reset, low
    input  wire logic       mdc,           // Management clock pin
    input  wire logic       mdio_i,        // Management data in
    output logic            mdio_o,        // Management data out
    output logic            mdio_oe,       // High while driving data
    input  wire logic [7:0] ev,            // Event pulses, flag order
    input  wire pic_pkg::pic_stat_t stat,  // Line and link status
    output pic_pkg::pic_ctrl_t ctrl,       // Control to the transceiver
    output logic            indicator_zero,// Indicator 0, high = on
    output logic            indicator_one, // Indicator 1, high = on
    output logic            intr_pin       // Interrupt, level selectable
);
    import pic_pkg::*;

    pic_regs_t   r;
    pic_regs_t   n;
    pic_req_t    req;
    logic [1:0]  pins_lvl;
    logic [7:0]  clr;
    logic        any_irq;

    // ------------------------------------------------------------
    // Pin synchronisation and serial management
    // ------------------------------------------------------------
    pic_sync3 #(
        .W (2)
    ) u_sync (
        .mclk   (mclk),
        .resetn (resetn),
        .din    ({mdc, mdio_i}),
        .dout   (pins_lvl)
    );

    pic_mdio_slave #(
        .PHY_ADDR (PHY_ADDR)
    ) u_mdio (
        .mclk     (mclk),
        .resetn   (resetn),
        .mdc_lvl  (pins_lvl[1]),
        .mdio_lvl (pins_lvl[0]),
        .rd_data  (r.rd_data),
        .req      (req),
        .mdio_o   (mdio_o),
        .mdio_oe  (mdio_oe)
    );

    // ------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        // Read of the interrupt word clears all flags it returned
        clr = 8'h00;
        if (req.rd && req.addr == REG_INT) begin
            clr = 8'hff;
        end
        // New event wins over a clear in the same cycle
        n.flags = (r.flags & ~clr) | ev;

        if (req.rd) begin
            if (req.addr == REG_INT) begin
                n.rd_data = {r.en, r.flags};
            end else if (req.addr == REG_CTL1) begin
                n.rd_data = 16'h0000;
                n.rd_data[CTL1_MODE_LSB+:2] = r.led_mode;
                n.rd_data[CTL1_POL]  = stat.polarity_reversed;
                n.rd_data[CTL1_MDIX] = stat.mdix_state;
                n.rd_data[CTL1_LOOP] = r.loopback;
            end else if (req.addr == REG_CTL2) begin
                n.rd_data = 16'h0000;
                n.rd_data[CTL2_XALG]     = r.xalg;
                n.rd_data[CTL2_MDIX_SEL] = r.mdix_sel;
                n.rd_data[CTL2_XDIS]     = r.xdis;
                n.rd_data[CTL2_ENERGY]   = stat.energy_detect;
                n.rd_data[CTL2_FORCE]    = r.force_link;
                n.rd_data[CTL2_INT_LVL]  = r.int_lvl;
            end else begin
                n.rd_data = 16'h0000;
            end
        end

        if (req.wr) begin
            if (req.addr == REG_INT) begin
                n.en = req.data[INT_EN_LSB+:8];
            end else if (req.addr == REG_CTL1) begin
                n.led_mode = req.data[CTL1_MODE_LSB+:2];
                n.loopback = req.data[CTL1_LOOP];
            end else if (req.addr == REG_CTL2) begin
                n.xalg       = req.data[CTL2_XALG];
                n.mdix_sel   = req.data[CTL2_MDIX_SEL];
                n.xdis       = req.data[CTL2_XDIS];
                n.force_link = req.data[CTL2_FORCE];
                n.int_lvl    = req.data[CTL2_INT_LVL];
            end
        end

        // Interrupt pin
        any_irq = |(r.flags & r.en);
        n.intr  = r.int_lvl ? any_irq : ~any_irq;

        // Indicator mapping; reserved codes leave both dark
        case (r.led_mode)
            MODE_SPD_LA: begin
                n.ind1 = stat.speed_100;
                n.ind0 = stat.link_up & ~stat.activity;
            end
            MODE_ACT_LK: begin
                n.ind1 = stat.activity;
                n.ind0 = stat.link_up;
            end
            default: begin
                n.ind1 = 1'h0;
                n.ind0 = 1'h0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            r.en         <= EN_RST;
            r.flags      <= FLAGS_RST;
            r.led_mode   <= MODE_RST;
            r.loopback   <= 1'h0;
            r.xalg       <= XALG_RST;
            r.mdix_sel   <= 1'h0;
            r.xdis       <= 1'h0;
            r.force_link <= 1'h0;
            r.int_lvl    <= 1'h0;
            r.rd_data    <= 16'h0000;
            r.intr       <= 1'h1;
            r.ind0       <= 1'h0;
            r.ind1       <= 1'h0;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign ctrl.remote_loopback            = r.loopback;
    assign ctrl.crossover_algorithm_select = r.xalg;
    assign ctrl.mdix_select                = r.mdix_sel;
    assign ctrl.auto_crossover_disable     = r.xdis;
    assign ctrl.force_link                 = r.force_link;
    assign indicator_zero = r.ind0;
    assign indicator_one  = r.ind1;
    assign intr_pin       = r.intr;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    a_flag_sets_event: assert property (
        (ev != 8'h00) |=> ((r.flags & $past(ev)) == $past(ev)))
        else $error("event did not set its flag");

    a_flag_read_clear: assert property (
        (req.rd && req.addr == REG_INT && ev == 8'h00 && !req.wr)
        |=> (r.flags == 8'h00) && (r.rd_data[7:0] == $past(r.flags)))
        else $error("flag read did not snapshot and clear");

    a_flag_hold_idle: assert property (
        (!req.rd && ev == 8'h00) |=> r.flags == $past(r.flags))
        else $error("flag changed without event or read");

    a_enable_write: assert property (
        (req.wr && req.addr == REG_INT)
        |=> r.en == $past(req.data[15:8]))
        else $error("enable write not stored");

    a_irq_level: assert property (
        ##1 (intr_pin == ($past(r.int_lvl) ? |($past(r.flags) & $past(r.en))
                           : ~|($past(r.flags) & $past(r.en)))))
        else $error("interrupt pin level wrong");

    a_irq_masked: assert property (
        (r.en == 8'h00 && !r.int_lvl) ##1 (r.en == 8'h00) |-> intr_pin)
        else $error("masked flags raised interrupt");

    a_ctl2_write: assert property (
        (req.wr && req.addr == REG_CTL2)
        |=> ctrl.crossover_algorithm_select == $past(req.data[15])
            && ctrl.mdix_select == $past(req.data[14])
            && ctrl.auto_crossover_disable == $past(req.data[13])
            && ctrl.force_link == $past(req.data[11]))
        else $error("second control write not applied");

    a_loopback_write: assert property (
        (req.wr && req.addr == REG_CTL1)
        |=> ctrl.remote_loopback == $past(req.data[7]))
        else $error("loopback write not applied");

    a_energy_read: assert property (
        (req.rd && req.addr == REG_CTL2)
        |=> r.rd_data[12] == $past(stat.energy_detect)
            && r.rd_data[15] == $past(r.xalg))
        else $error("second control read wrong");

    a_polarity_read: assert property (
        (req.rd && req.addr == REG_CTL1)
        |=> r.rd_data[13] == $past(stat.polarity_reversed))
        else $error("polarity status read wrong");

    a_indicator_mode: assert property (
        (r.led_mode == MODE_ACT_LK) ##1 (r.led_mode == MODE_ACT_LK)
        |-> indicator_one == $past(stat.activity)
            && indicator_zero == $past(stat.link_up))
        else $error("indicator mapping wrong");

    a_unmapped_zero: assert property (
        (req.rd && req.addr != REG_INT && req.addr != REG_CTL1
         && req.addr != REG_CTL2) |=> r.rd_data == 16'h0000)
        else $error("unmapped read not zero");

    a_mode_write: assert property (
        (req.wr && req.addr == REG_CTL1)
        |=> r.led_mode == $past(req.data[15:14]))
        else $error("indicator mode write not stored");

    a_irq_level_write: assert property (
        (req.wr && req.addr == REG_CTL2)
        |=> r.int_lvl == $past(req.data[9]))
        else $error("interrupt level write not stored");

    a_ctl2_read: assert property (
        (req.rd && req.addr == REG_CTL2)
        |=> r.rd_data[14:13] == $past({r.mdix_sel, r.xdis})
            && r.rd_data[11] == $past(r.force_link) && r.rd_data[9] == $past(r.int_lvl))
        else $error("second control field read wrong");

    a_mdix_state_read: assert property (
        (req.rd && req.addr == REG_CTL1)
        |=> r.rd_data[11] == $past(stat.mdix_state))
        else $error("crossover state read wrong");

    a_flags_need_event: assert property (
        (ev == 8'h00) |=> (r.flags & ~$past(r.flags)) == 8'h00)
        else $error("flag set without its event");

    a_indicator_speed: assert property (
        (r.led_mode == MODE_SPD_LA) ##1 (r.led_mode == MODE_SPD_LA)
        |-> indicator_one == $past(stat.speed_100)
            && indicator_zero == $past(stat.link_up && !stat.activity))
        else $error("speed indicator mapping wrong");

    a_indicator_dark: assert property (
        r.led_mode[1] ##1 r.led_mode[1] |-> !indicator_zero && !indicator_one)
        else $error("reserved indicator mode lit");

    a_turnaround_zero: assert property (
        $rose(mdio_oe) |-> !mdio_o)
        else $error("turnaround bit not driven low");

    // ------------------------------------------------------------
    // Reset values and bit positions
    // ------------------------------------------------------------
    a_reset_values: assert property (
        disable iff (1'b0)
        !resetn |=> r.en == EN_RST && r.flags == FLAGS_RST && r.led_mode == MODE_RST
            && r.xalg == XALG_RST && !r.int_lvl && intr_pin && !mdio_oe)
        else $error("register not at reset value");

    for (genvar i = 0; i < 8; i++) begin : g_ev_map
        a_event_bit_map: assert property (
            (req.rd && req.addr == REG_INT)
            |=> r.rd_data[INT_EN_LSB + i] == $past(r.en[i])
                && r.rd_data[i] == $past(r.flags[i]))
            else $error("event enable or flag in wrong bit");
    end

    c_flag_read: cover property (
        (req.rd && req.addr == REG_INT && r.flags != 8'h00));
    c_irq_raised: cover property ($changed(intr_pin));
    c_ctl2_write: cover property (req.wr && req.addr == REG_CTL2);
    c_mode_act: cover property (r.led_mode == MODE_ACT_LK);
    c_mode_dark: cover property (r.led_mode[1]);
endmodule
`default_nettype wire

// ### hdl/pic_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module pic_sync3 #(
    parameter int W = 1
) (
    input  wire logic         mclk,   // Device clock
    input  wire logic         resetn, // Sync reset, low
    input  wire logic [W-1:0] din,    // Asynchronous inputs
    output logic      [W-1:0] dout    // Filtered levels
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    if (W < 1) begin : g_chk
        $error("pic_sync3: W must be at least 1");
    end

    // ------------------------------------------------------------
    // Three stages; a change counts once stages two and three agree
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            dout <= '0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < W; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    dout[i] <= s3_r[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/pic_mdio_master.sv
`timescale 1ns/1ps
`default_nettype none
module pic_mdio_master (
    input  wire logic mclk,      // Device clock
    input  wire logic mdio_line, // Resolved data line
    output var logic  mdc,       // Management clock
    output var logic  mdio_out,  // Data driven
    output var logic  mdio_drv   // High while driving
);
    initial begin
        mdc = 1'b0;
        mdio_out = 1'b1;
        mdio_drv = 1'b0;
    end

    // ------------------------------------------------------------
    // One frame; clock stands low between frames
    // ------------------------------------------------------------
    task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                        input logic [15:0] wd, input int pre, output logic [15:0] rd);
        logic [31:0] fr;
        int          k;
        fr = {2'b01, op, phy, ra, 2'b10, wd};
        rd = 16'h0000;
        for (int s = 0; s < pre + 32; s++) begin
            k = s - pre;
            @(posedge mclk);
            mdc <= 1'b0;
            mdio_drv <= (k < 14) || (op == 2'h1);
            mdio_out <= (k < 0) ? 1'b1 : fr[5'(31 - k)];
            repeat (8) @(posedge mclk);
            if (k >= 16) begin
                rd[4'(31 - k)] = mdio_line;
            end
            mdc <= 1'b1;
            repeat (8) @(posedge mclk);
        end
        mdc <= 1'b0;
        mdio_drv <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### tb/pic_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pic_regs_tb;
    import pic_pkg::*;
    typedef struct packed {
        logic [7:0] ev;
        logic [7:0] en;
        logic       act;
    } pic_row_t;
    logic        mclk;
    logic        resetn;
    logic        mdc;
    logic        mdio_o;
    logic        mdio_oe;
    logic        m_out;
    logic        m_drv;
    logic        line;
    logic [7:0]  ev;
    pic_stat_t   stat;
    pic_ctrl_t   ctrl;
    logic        ind0;
    logic        ind1;
    logic        intr_pin;
    logic [15:0] r;
    int          n_errors;
    int          n_compared;
    pic_row_t    rows [9];
    logic [1:0]  ind_exp [4];

    // Pull-up when nobody drives
    assign line = mdio_oe ? mdio_o : (m_drv ? m_out : 1'b1);

    pic_regs dut_u (.mclk(mclk), .resetn(resetn), .mdc(mdc), .mdio_i(line), .mdio_o(mdio_o),
        .mdio_oe(mdio_oe), .ev(ev), .stat(stat), .ctrl(ctrl), .indicator_zero(ind0),
        .indicator_one(ind1), .intr_pin(intr_pin));
    pic_mdio_master master_u (.mclk(mclk), .mdio_line(line), .mdc(mdc), .mdio_out(m_out),
        .mdio_drv(m_drv));

    always #4 mclk = ~mclk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        master_u.xfer(OP_WR, 5'h01, ra, d, 32, r);
    endtask
    task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
        master_u.xfer(OP_RD, 5'h01, ra, 16'h0000, 32, r);
        chk(r, exp);
    endtask
    task automatic pulse(input logic [7:0] p);
        @(posedge mclk);
        ev <= p;
        @(posedge mclk);
        ev <= 8'h00;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic do_reset();
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        #1;
    endtask
    task automatic summarize();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge mclk);
        n_errors++;
        summarize();
    end

    initial begin
        mclk = 1'b0;
        ev = 8'h00;
        stat = '0;
        n_errors = 0;
        n_compared = 0;
        rows = '{'{8'h80, 8'h80, 1'b1},
                 '{8'h40, 8'h40, 1'b1},
                 '{8'h20, 8'h20, 1'b1},
                 '{8'h10, 8'h10, 1'b1},
                 '{8'h08, 8'h08, 1'b1},
                 '{8'h04, 8'h04, 1'b1},
                 '{8'h02, 8'h02, 1'b1},
                 '{8'h01, 8'h01, 1'b1},
                 '{8'h81, 8'h7e, 1'b0}};
        ind_exp = '{2'b11, 2'b01, 2'b00, 2'b00};
        do_reset();
        chk({11'h0, ctrl}, 16'h0008);
        chk({15'h0, intr_pin}, 16'h0001);
        rd(REG_INT, 16'h0000);
        rd(REG_CTL1, 16'h0000);
        rd(REG_CTL2, 16'h8000);
        $display("test reset values done");
        foreach (rows[i]) begin
            wr(REG_INT, {rows[i].en, 8'hff});
            pulse(rows[i].ev);
            chk({15'h0, intr_pin}, {15'h0, ~rows[i].act});
            rd(REG_INT, {rows[i].en, rows[i].ev});
            rd(REG_INT, {rows[i].en, 8'h00});
            chk({15'h0, intr_pin}, 16'h0001);
        end
        $display("test event rows done");
        wr(REG_CTL2, 16'h8200);
        #1;
        chk({15'h0, intr_pin}, 16'h0000);
        wr(REG_INT, 16'h0100);
        pulse(8'h01);
        chk({15'h0, intr_pin}, 16'h0001);
        rd(REG_INT, 16'h0101);
        chk({15'h0, intr_pin}, 16'h0000);
        $display("test polarity done");
        stat <= pic_stat_t'(6'h38);
        wr(REG_CTL1, 16'hffff);
        rd(REG_CTL1, 16'he880);
        wr(REG_CTL2, 16'hffff);
        rd(REG_CTL2, 16'hfa00);
        chk({11'h0, ctrl}, 16'h001f);
        stat <= pic_stat_t'(6'h05);
        wr(REG_CTL2, 16'h0000);
        rd(REG_CTL2, 16'h0000);
        chk({11'h0, ctrl}, 16'h0010);
        $display("test controls done");
        for (int m = 0; m < 4; m++) begin
            wr(REG_CTL1, {m[1:0], 14'h0000});
            repeat (4) @(posedge mclk);
            #1;
            chk({14'h0, ind1, ind0}, {14'h0, ind_exp[m]});
        end
        $display("test indicator modes done");
        master_u.xfer(OP_WR, 5'h02, REG_INT, 16'hff00, 32, r);
        master_u.xfer(OP_WR, 5'h01, REG_INT, 16'hff00, 31, r);
        master_u.xfer(2'h3, 5'h01, REG_INT, 16'hff00, 32, r);
        rd(REG_INT, 16'h0100);
        rd(5'h10, 16'h0000);
        $display("test refusals done");
        do_reset();
        rd(REG_INT, 16'h0000);
        rd(REG_CTL2, 16'h8000);
        chk({11'h0, ctrl}, 16'h0008);
        $display("test mid-run reset done");
        summarize();
    end
endmodule
`default_nettype wire
